/* File: logic/ccw_calendar_core.sv */
// Summary of operation
// [RULE1] Freeze request stops second-to-year counters
// [RULE2] Freeze takes effect within one subclock
// [RULE3] Carry seen while frozen applied on resume
// [RULE4] Second write discards pending frozen carry
// [RULE5] Software finishes access within one second
// [RULE6] Software writes flags as ones, full byte
// [RULE7] Fixed-cycle and alarm share one interrupt
// [RULE8] Interval period two-to-six..twelve subclocks, enabled
// [RULE9] Interval select changed only while disabled
// [RULE10] Divided pin gated, 512 Hz or 16 kHz
// [RULE11] Never enable both clock outputs together
// [RULE12] Disabled divided pin goes low quickly
// [RULE13] Subcounter counts one second, carries seconds
// [RULE14] Second write clears the subcounter
// [RULE15] Corrected limit may exceed 7FFF, reads loose
// [RULE16] Counter writes buffered, land within two ticks
// [RULE17] Written counter ignores incoming lower carry
// [RULE18] Seconds and minutes count BCD 0 to 59
// [RULE19] Twelve-hour codes with bit 5 as PM
// [RULE20] Hour resets 12H, 00H in 24-hour mode
// [RULE21] Day wraps by month length and leap
// [RULE22] Weekday advances with the day counter
// [RULE23] Freeze status flag shows freeze in effect
// [RULE24] Status flags cleared only by writing zero
// [RULE25] Weekday wraps from 6 to 0
`include "ccw_defs.svh"
module ccw_calendar_core (
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire logic               clk_en,
  input  wire logic               crystal_subclock,
  input  wire logic [19:0]        sfr_addr,
  input  wire logic               sfr_wr,
  input  wire ccw_pkg::ccw_byte_t sfr_wdata,
  input  wire logic [15:0]        drift_correction,
  input  wire logic [4:0]         month_bcd,
  input  wire logic               leap_year,
  input  wire logic               alarm_match,
  output logic [15:0]             sfr_rdata,
  output logic                    calendar_irq,
  output logic                    interval_irq,
  output logic                    divided_clock_pin,
  output logic                    day_carry
);
  import ccw_pkg::*;

  // Live counters and control registers
  logic [15:0] one_second_subcounter;  // Subsecond count
  ccw_byte_t   seconds_count;          // BCD seconds
  ccw_byte_t   minutes_count;          // BCD minutes
  ccw_byte_t   hours_count;            // BCD hours
  ccw_byte_t   day_of_month_count;     // BCD day
  ccw_byte_t   weekday_count;          // 0 to 6
  ccw_byte_t   alarm_wait_control;     // Control 1 writable part
  ccw_byte_t   rtc_control0;           // Run, format, fixed-cycle select
  ccw_byte_t   interval_and_divout_control;
  ccw_freeze_t freeze_state;           // Freeze handshake
  logic        carry_pending;          // Second carry held while frozen
  logic        fixed_cycle_flag;       // Sticky fixed-cycle event
  logic        alarm_match_flag;       // Sticky alarm event
  logic        hour_written;           // Hour touched since reset
  logic [4:0]  pend_valid;             // Buffered writes waiting
  ccw_byte_t   pend_data [5];          // Buffered write values
  logic [11:0] prescaler;              // Free subclock divider

  // Decoded helpers
  logic counter_freeze_request;
  logic counter_freeze_status;
  logic hour_format_select;
  logic sub_ovf, sub_half, sec_step, sec_wrap, min_wrap, hour_wrap, day_wrap;
  logic [2:0] ivl_sel;
  logic [11:0] ivl_mask;  // Prescaler bits that must all be one
  logic ivl_hit;
  logic fixed_event;      // Selected fixed-cycle source fired
  logic alarm_event;      // Alarm match while matching is on
  ccw_byte_t day_last;
  ccw_byte_t next_hour;

  // Increment of a two-digit BCD byte
  function automatic ccw_byte_t bcd_inc(input ccw_byte_t v);
    ccw_byte_t r;
    r = v;
    if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  assign counter_freeze_request = alarm_wait_control[`CCW_C1_FRZ_REQ];
  assign counter_freeze_status  = (freeze_state == CCW_FROZEN);
  assign hour_format_select     = rtc_control0[`CCW_C0_FORMAT];
  assign ivl_sel = interval_and_divout_control[`CCW_C2_IVL_LO +: 3];

  // Write strobe per buffered counter
  logic [4:0] wr_hit;
  assign wr_hit[CCW_W_SEC]  = sfr_wr && (sfr_addr == `CCW_ADDR_SEC);
  assign wr_hit[CCW_W_MIN]  = sfr_wr && (sfr_addr == `CCW_ADDR_MIN);
  assign wr_hit[CCW_W_HOUR] = sfr_wr && (sfr_addr == `CCW_ADDR_HOUR);
  assign wr_hit[CCW_W_DAY]  = sfr_wr && (sfr_addr == `CCW_ADDR_DAY);
  assign wr_hit[CCW_W_WEEK] = sfr_wr && (sfr_addr == `CCW_ADDR_WEEK);

  // Carry chain, all qualified by a subclock tick
  always_comb begin
    // [RULE15] Corrected overflow limit
    sub_ovf  = crystal_subclock && rtc_control0[`CCW_C0_RUN]
               && (one_second_subcounter >= drift_correction);
    sub_half = crystal_subclock && rtc_control0[`CCW_C0_RUN]
               && (one_second_subcounter == `CCW_SUBC_HALF);
    // [RULE3] Held carry released on resume
    sec_step = crystal_subclock && rtc_control0[`CCW_C0_RUN]
               && !counter_freeze_status && (sub_ovf || carry_pending)
               && !pend_valid[CCW_W_SEC];
    // [RULE18] Wrap at 59
    sec_wrap  = sec_step && (seconds_count == `CCW_BCD_59);
    // [RULE17] Carry into a written counter dropped
    min_wrap  = sec_wrap && !pend_valid[CCW_W_MIN]
                && (minutes_count == `CCW_BCD_59);
    hour_wrap = min_wrap && !pend_valid[CCW_W_HOUR]
                && (hour_format_select ? (hours_count == `CCW_HOUR_23)
                                       : (hours_count == 8'h31));
    // [RULE21] Month length from month and leap year
    if (month_bcd == 5'h02) begin
      day_last = leap_year ? 8'h29 : 8'h28;
    end else if (month_bcd == 5'h04 || month_bcd == 5'h06 ||
                 month_bcd == 5'h09 || month_bcd == 5'h11) begin
      day_last = 8'h30;
    end else begin
      day_last = 8'h31;
    end
    day_wrap = hour_wrap && !pend_valid[CCW_W_DAY]
               && (day_of_month_count == day_last);
    // [RULE19] Twelve-hour sequence, 11 to 32 noon, 31 to 12 midnight
    if (hour_format_select) begin
      next_hour = (hours_count == `CCW_HOUR_23) ? 8'h00 : bcd_inc(hours_count);
    end else if (hours_count == 8'h12) begin
      next_hour = 8'h01;
    end else if (hours_count == 8'h11) begin
      next_hour = 8'h32;
    end else if (hours_count == 8'h32) begin
      next_hour = 8'h21;
    end else if (hours_count == 8'h31) begin
      next_hour = 8'h12;
    end else begin
      next_hour = bcd_inc(hours_count);
    end
    // [RULE8] Codes 110 and 111 both give the longest period
    ivl_mask = ~(12'hFFF << (`CCW_IVL_MIN_EXP
                             + ((ivl_sel > `CCW_IVL_MAX_SEL) ? 3'h6 : ivl_sel)));
    ivl_hit = crystal_subclock && interval_and_divout_control[`CCW_C2_IVL_EN]
              && ((prescaler & ivl_mask) == ivl_mask);
  end

  // Freeze handshake, answered on the next subclock tick
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      freeze_state <= CCW_RUN;
    end else if (clk_en && crystal_subclock) begin
      // [RULE1] Freeze follows the request
      // [RULE2] Within one subclock tick
      // [RULE23] Status reflects the freeze in effect
      freeze_state <= counter_freeze_request ? CCW_FROZEN : CCW_RUN;
    end
  end

  // Subcounter and the carry kept while frozen
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      one_second_subcounter <= `CCW_RST_SUBC;
      carry_pending         <= 1'b0;
    end else if (clk_en && crystal_subclock) begin
      if (pend_valid[CCW_W_SEC]) begin
        // [RULE14] Second write restarts the second
        one_second_subcounter <= `CCW_RST_SUBC;
        // [RULE4] Pending carry discarded
        carry_pending <= 1'b0;
      end else begin
        if (sub_ovf) begin
          // [RULE13] Count to the limit, then restart
          one_second_subcounter <= `CCW_RST_SUBC;
        end else if (rtc_control0[`CCW_C0_RUN]) begin
          one_second_subcounter <= one_second_subcounter + 16'h0001;
        end
        // [RULE3] Remember the overflow while frozen
        if (sub_ovf && counter_freeze_status) begin
          carry_pending <= 1'b1;
        end else if (sec_step) begin
          carry_pending <= 1'b0;
        end
      end
    end
  end

  // Buffered writes, applied on the next subclock tick
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pend_valid <= 5'b0_0000;
      for (int i = 0; i < 5; i++) begin
        pend_data[i] <= 8'h00;
      end
    end else if (clk_en) begin
      for (int i = 0; i < 5; i++) begin
        // [RULE16] Write held until a tick, a new write wins
        if (wr_hit[i]) begin
          pend_valid[i] <= 1'b1;
          pend_data[i]  <= sfr_wdata;
        end else if (crystal_subclock) begin
          pend_valid[i] <= 1'b0;
        end
      end
    end
  end

  // Calendar counters
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      seconds_count      <= `CCW_RST_SEC;
      minutes_count      <= `CCW_RST_MIN;
      hours_count        <= `CCW_RST_HOUR12;
      day_of_month_count <= `CCW_RST_DAY;
      weekday_count      <= `CCW_RST_WEEK;
      hour_written       <= 1'b0;
    end else if (clk_en) begin
      // [RULE20] 24-hour mode picked before any hour write reads 00H
      if (sfr_wr && sfr_addr == `CCW_ADDR_CTRL0 && sfr_wdata[`CCW_C0_FORMAT]
          && !hour_written && hours_count == `CCW_RST_HOUR12) begin
        hours_count <= `CCW_RST_HOUR24;
      end
      if (wr_hit[CCW_W_HOUR]) begin
        hour_written <= 1'b1;
      end
      if (crystal_subclock) begin
        // [RULE18] Seconds in BCD
        if (pend_valid[CCW_W_SEC]) begin
          seconds_count <= pend_data[CCW_W_SEC];
        end else if (sec_step) begin
          seconds_count <= sec_wrap ? 8'h00 : bcd_inc(seconds_count);
        end
        // [RULE17] Written value beats a carry
        if (pend_valid[CCW_W_MIN]) begin
          minutes_count <= pend_data[CCW_W_MIN];
        end else if (sec_wrap) begin
          minutes_count <= min_wrap ? 8'h00 : bcd_inc(minutes_count);
        end
        if (pend_valid[CCW_W_HOUR]) begin
          hours_count <= pend_data[CCW_W_HOUR];
        end else if (min_wrap) begin
          hours_count <= next_hour;
        end
        // [RULE21] Day restarts at 01
        if (pend_valid[CCW_W_DAY]) begin
          day_of_month_count <= pend_data[CCW_W_DAY];
        end else if (hour_wrap) begin
          day_of_month_count <= day_wrap ? 8'h01 : bcd_inc(day_of_month_count);
        end
        // [RULE22] Weekday follows the day
        if (pend_valid[CCW_W_WEEK]) begin
          weekday_count <= pend_data[CCW_W_WEEK];
        end else if (hour_wrap) begin
          // [RULE25] Wrap after 6
          weekday_count <= (weekday_count >= `CCW_WEEK_LAST) ? 8'h00
                                                              : weekday_count + 8'h01;
        end
      end
    end
  end

  // Control registers and sticky flags
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rtc_control0                <= `CCW_RST_CTRL;
      alarm_wait_control          <= `CCW_RST_CTRL;
      interval_and_divout_control <= `CCW_RST_CTRL;
      fixed_cycle_flag            <= 1'b0;
      alarm_match_flag            <= 1'b0;
    end else if (clk_en) begin
      if (sfr_wr && sfr_addr == `CCW_ADDR_CTRL0) begin
        rtc_control0 <= sfr_wdata & 8'hBF;
      end
      if (sfr_wr && sfr_addr == `CCW_ADDR_CTRL1) begin
        alarm_wait_control <= sfr_wdata & 8'hC1;
      end
      if (sfr_wr && sfr_addr == `CCW_ADDR_CTRL2) begin
        interval_and_divout_control <= sfr_wdata & 8'hE7;
      end
      // [RULE24] Zero clears, one is ignored, a new event wins
      if (fixed_event) begin
        fixed_cycle_flag <= 1'b1;
      end else if (sfr_wr && sfr_addr == `CCW_ADDR_CTRL1
                   && !sfr_wdata[`CCW_C1_FIXED_FLAG]) begin
        fixed_cycle_flag <= 1'b0;
      end
      if (alarm_event) begin
        alarm_match_flag <= 1'b1;
      end else if (sfr_wr && sfr_addr == `CCW_ADDR_CTRL1
                   && !sfr_wdata[`CCW_C1_ALARM_FLAG]) begin
        alarm_match_flag <= 1'b0;
      end
    end
  end

  // Fixed-cycle selection and alarm qualification
  always_comb begin
    case (rtc_control0[`CCW_C0_CT_LO +: 3])
      3'h1:    fixed_event = sub_half || sec_step;
      3'h2:    fixed_event = sec_step;
      3'h3:    fixed_event = sec_wrap;
      3'h4:    fixed_event = min_wrap;
      3'h5:    fixed_event = hour_wrap;
      3'h6:    fixed_event = day_wrap;
      3'h7:    fixed_event = day_wrap;
      default: fixed_event = 1'b0;
    endcase
    // Alarm only counts while match operation is on
    alarm_event = alarm_match && alarm_wait_control[`CCW_C1_ALARM_EN];
  end

  // Interrupt pulses, divider and pin
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prescaler         <= 12'h000;
      calendar_irq      <= 1'b0;
      interval_irq      <= 1'b0;
      divided_clock_pin <= 1'b0;
      day_carry         <= 1'b0;
    end else if (clk_en) begin
      if (crystal_subclock) begin
        prescaler <= prescaler + 12'h001;
      end
      // [RULE7] One request for both sources
      calendar_irq <= fixed_event
                      || (alarm_event && alarm_wait_control[`CCW_C1_ALARM_IE]);
      // [RULE8] Interval pulse only when enabled
      interval_irq <= ivl_hit;
      day_carry    <= clk_en && crystal_subclock && day_wrap;
      // [RULE10] Gated output, rate from the select bit
      // [RULE12] Disabled pin falls low on the next cycle
      if (interval_and_divout_control[`CCW_C2_DIV_OE]) begin
        divided_clock_pin <= interval_and_divout_control[`CCW_C2_DIV_FREQ]
                             ? prescaler[`CCW_DIV_16K_BIT]
                             : prescaler[`CCW_DIV_512_BIT];
      end else begin
        divided_clock_pin <= 1'b0;
      end
    end
  end

  // Registered read port, unmapped addresses read zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sfr_rdata <= 16'h0000;
    end else if (clk_en) begin
      // [RULE15] Running subcounter read as it stands
      if (sfr_addr == `CCW_ADDR_SUBC_LO) begin
        sfr_rdata <= one_second_subcounter;
      end else if (sfr_addr == `CCW_ADDR_SUBC_HI) begin
        sfr_rdata <= {8'h00, one_second_subcounter[15:8]};
      end else if (sfr_addr == `CCW_ADDR_SEC) begin
        sfr_rdata <= {8'h00, seconds_count};
      end else if (sfr_addr == `CCW_ADDR_MIN) begin
        sfr_rdata <= {8'h00, minutes_count};
      end else if (sfr_addr == `CCW_ADDR_HOUR) begin
        sfr_rdata <= {8'h00, hours_count};
      end else if (sfr_addr == `CCW_ADDR_WEEK) begin
        sfr_rdata <= {8'h00, weekday_count};
      end else if (sfr_addr == `CCW_ADDR_DAY) begin
        sfr_rdata <= {8'h00, day_of_month_count};
      end else if (sfr_addr == `CCW_ADDR_CTRL0) begin
        sfr_rdata <= {8'h00, rtc_control0};
      end else if (sfr_addr == `CCW_ADDR_CTRL1) begin
        // [RULE23] Status visible to software
        sfr_rdata <= {8'h00, alarm_wait_control[7:6], 1'b0, alarm_match_flag,
                      fixed_cycle_flag, 1'b0, counter_freeze_status,
                      counter_freeze_request};
      end else if (sfr_addr == `CCW_ADDR_CTRL2) begin
        sfr_rdata <= {8'h00, interval_and_divout_control};
      end else begin
        sfr_rdata <= 16'h0000;
      end
    end
  end

endmodule // ccw_calendar_core

/* File: logic/ccw_defs.svh */
`ifndef CCW_DEFS_SVH
`define CCW_DEFS_SVH

// Register addresses on the special-function register port
`define CCW_ADDR_SUBC_LO   20'hF_FF90
`define CCW_ADDR_SUBC_HI   20'hF_FF91
`define CCW_ADDR_SEC       20'hF_FF92
`define CCW_ADDR_MIN       20'hF_FF93
`define CCW_ADDR_HOUR      20'hF_FF94
`define CCW_ADDR_WEEK      20'hF_FF95
`define CCW_ADDR_DAY       20'hF_FF96
`define CCW_ADDR_CTRL0     20'hF_FF9D
`define CCW_ADDR_CTRL1     20'hF_FF9E
`define CCW_ADDR_CTRL2     20'hF_FF9F

// Reset values
`define CCW_RST_SUBC       16'h0000
`define CCW_RST_SEC        8'h00
`define CCW_RST_MIN        8'h00
`define CCW_RST_HOUR12     8'h12
`define CCW_RST_HOUR24     8'h00
`define CCW_RST_DAY        8'h01
`define CCW_RST_WEEK       8'h00
`define CCW_RST_CTRL       8'h00

// Control 0 fields
`define CCW_C0_RUN         7
`define CCW_C0_CLK32K_OE   4
`define CCW_C0_FORMAT      3
`define CCW_C0_CT_LO       0

// Control 1 fields
`define CCW_C1_ALARM_EN    7
`define CCW_C1_ALARM_IE    6
`define CCW_C1_ALARM_FLAG  4
`define CCW_C1_FIXED_FLAG  3
`define CCW_C1_FRZ_STATUS  1
`define CCW_C1_FRZ_REQ     0

// Control 2 fields
`define CCW_C2_IVL_EN      7
`define CCW_C2_DIV_OE      6
`define CCW_C2_DIV_FREQ    5
`define CCW_C2_IVL_LO      0

// Counting limits and divider taps; subcounter limits in subsystem clock ticks, BCD limits as codes, taps as prescaler bits
`define CCW_SUBC_TOP       16'h7FFF
`define CCW_SUBC_HALF      16'h3FFF
`define CCW_BCD_59         8'h59
`define CCW_HOUR_23        8'h23
`define CCW_IVL_MIN_EXP    6
`define CCW_IVL_MAX_SEL    3'h6
`define CCW_DIV_512_BIT    5
`define CCW_DIV_16K_BIT    0
`define CCW_WEEK_LAST      8'h06

`endif

/* File: logic/ccw_pkg.sv */
package ccw_pkg;
  // One byte of register or BCD counter
  typedef logic [7:0] ccw_byte_t;
  // Freeze handshake states, one-hot
  typedef enum logic [1:0] {
    CCW_RUN    = 2'b01,
    CCW_FROZEN = 2'b10
  } ccw_freeze_t;
  // Index of the buffered counter writes
  typedef enum logic [2:0] {
    CCW_W_SEC  = 3'd0,
    CCW_W_MIN  = 3'd1,
    CCW_W_HOUR = 3'd2,
    CCW_W_DAY  = 3'd3,
    CCW_W_WEEK = 3'd4
  } ccw_wsel_t;
endpackage

/* File: verif/ccw_calendar_asserts.sv */
`include "ccw_defs.svh"
module ccw_calendar_asserts
  import ccw_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               reset,
  input wire logic               clk_en,
  input wire logic               crystal_subclock,
  input wire logic [19:0]        sfr_addr,
  input wire logic               sfr_wr,
  input wire ccw_pkg::ccw_byte_t sfr_wdata,
  input wire logic [15:0]        drift_correction,
  input wire logic [4:0]         month_bcd,
  input wire logic               leap_year,
  input wire logic               alarm_match,
  input wire logic [15:0]        sfr_rdata,
  input wire logic               calendar_irq,
  input wire logic               interval_irq,
  input wire logic               divided_clock_pin,
  input wire logic               day_carry
);
  logic ivl_en;  // Interval enable as last written
  logic div_oe;  // Divided pin enable as last written

  // Mirror the gate bits from bus writes; the core's own copy is hidden
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ivl_en <= 1'b0;
      div_oe <= 1'b0;
    end else if (clk_en && sfr_wr && sfr_addr == `CCW_ADDR_CTRL2) begin
      ivl_en <= sfr_wdata[`CCW_C2_IVL_EN];
      div_oe <= sfr_wdata[`CCW_C2_DIV_OE];
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  chk_sec_range:
    assert property ($past(sfr_addr) == `CCW_ADDR_SEC |-> sfr_rdata <= 16'h0059
      && sfr_rdata[3:0] <= 4'h9) else $error("second count out of range");
  chk_min_range:
    assert property ($past(sfr_addr) == `CCW_ADDR_MIN |-> sfr_rdata <= 16'h0059
      && sfr_rdata[3:0] <= 4'h9) else $error("minute count out of range");
  chk_hour_code:
    assert property ($past(sfr_addr) == `CCW_ADDR_HOUR |-> sfr_rdata <= 16'h0032
      && sfr_rdata[3:0] <= 4'h9) else $error("hour code out of range");
  chk_week_range:
    assert property ($past(sfr_addr) == `CCW_ADDR_WEEK |-> sfr_rdata <= 16'h0006)
    else $error("weekday out of range");
  chk_ivl_gate:
    assert property ((!ivl_en) [*3] |-> !interval_irq)
    else $error("interval pulse while disabled");
  chk_div_gate:
    assert property ((!div_oe) [*4] |-> !divided_clock_pin)
    else $error("divided pin high while disabled");
  chk_irq_pulse:
    assert property (calendar_irq |=> !calendar_irq)
    else $error("calendar request longer than one cycle");
  chk_carry_pulse:
    assert property (day_carry |=> !day_carry)
    else $error("day carry longer than one cycle");
  chk_ivl_pulse:
    assert property (interval_irq |=> !interval_irq)
    else $error("interval request longer than one cycle");

  cover property (day_carry);
  cover property (interval_irq);
  cover property (calendar_irq);
endmodule  // ccw_calendar_asserts

bind ccw_calendar_core ccw_calendar_asserts u_chk (
  .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .crystal_subclock(crystal_subclock),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
  .drift_correction(drift_correction), .month_bcd(month_bcd), .leap_year(leap_year),
  .alarm_match(alarm_match), .sfr_rdata(sfr_rdata), .calendar_irq(calendar_irq),
  .interval_irq(interval_irq), .divided_clock_pin(divided_clock_pin), .day_carry(day_carry)
);

/* File: verif/tb.sv */
`include "ccw_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ccw_pkg::*;
  logic        ref_clk, reset, clk_en, crystal_subclock, sfr_wr, leap_year, alarm_match;
  logic        calendar_irq, interval_irq, divided_clock_pin, day_carry, div_q;
  logic [19:0] sfr_addr;      // Register address
  ccw_byte_t   sfr_wdata;     // Write byte
  logic [15:0] drift_correction, sfr_rdata;
  logic [4:0]  month_bcd;     // Month from the outside counter
  int          miscompares = 0, comparisons = 0, j, k;
  int          n_cal = 0, n_ivl = 0, n_div = 0, n_carry = 0;
  // Reset image: SUBC, SEC, MIN, HOUR, DAY, CTRL2, unmapped
  logic [19:0] ra[7] = '{`CCW_ADDR_SUBC_LO, `CCW_ADDR_SEC, `CCW_ADDR_MIN, `CCW_ADDR_HOUR,
                         `CCW_ADDR_DAY, `CCW_ADDR_CTRL2, 20'hF_FF80};
  logic [15:0] re[7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0012, 16'h0001, 16'h0000, 16'h0000};
  // Rollover cases: 24h, hour, day, week, month, leap, hour/day/week after, day carries
  logic [7:0]  cs[6][10] = '{
    '{8'h00, 8'h11, 8'h05, 8'h02, 8'h01, 8'h00, 8'h32, 8'h05, 8'h02, 8'h00},
    '{8'h00, 8'h31, 8'h30, 8'h06, 8'h04, 8'h00, 8'h12, 8'h01, 8'h00, 8'h01},
    '{8'h00, 8'h12, 8'h31, 8'h01, 8'h01, 8'h00, 8'h01, 8'h31, 8'h01, 8'h00},
    '{8'h01, 8'h23, 8'h28, 8'h03, 8'h02, 8'h00, 8'h00, 8'h01, 8'h04, 8'h01},
    '{8'h01, 8'h23, 8'h28, 8'h00, 8'h02, 8'h01, 8'h00, 8'h29, 8'h01, 8'h00},
    '{8'h01, 8'h09, 8'h31, 8'h05, 8'h12, 8'h00, 8'h10, 8'h31, 8'h05, 8'h00}};

  ccw_calendar_core dut (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .crystal_subclock(crystal_subclock),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .drift_correction(drift_correction), .month_bcd(month_bcd), .leap_year(leap_year),
    .alarm_match(alarm_match), .sfr_rdata(sfr_rdata), .calendar_irq(calendar_irq),
    .interval_irq(interval_irq), .divided_clock_pin(divided_clock_pin), .day_carry(day_carry)
  );

  // 250 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Count pulses and pin rises; they are too short to catch from the main flow
  always @(posedge ref_clk) begin
    n_cal   <= n_cal + int'(calendar_irq);
    n_ivl   <= n_ivl + int'(interval_irq);
    n_carry <= n_carry + int'(day_carry);
    n_div   <= n_div + int'(divided_clock_pin && !div_q);
    div_q   <= divided_clock_pin;
  end

  // Drive just after the edge, same offset every time
  task automatic cyc(int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Subsystem ticks, one idle cycle between pulses
  task automatic ticks(int n);
    repeat (n) begin
      crystal_subclock = 1'b1;
      cyc();
      crystal_subclock = 1'b0;
      cyc();
    end
  endtask

  task automatic wr(logic [19:0] a, ccw_byte_t d);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    cyc();
    sfr_wr    = 1'b0;
    cyc();
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Address taken at one edge, data settled after it
  task automatic rd(logic [19:0] a, logic [15:0] exp, logic [15:0] m = 16'hFFFF);
    sfr_addr = a;
    cyc();
    chk(sfr_rdata & m, exp);
  endtask

  task automatic stop_test();
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog for a hung run
  initial begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    stop_test();
  end

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    crystal_subclock = 1'b0;
    sfr_addr = 20'h0_0000;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    drift_correction = 16'h7FFF;
    month_bcd = 5'h01;
    leap_year = 1'b0;
    alarm_match = 1'b0;
    cyc(10);
    reset = 1'b0;
    for (int i = 0; i < 7; i++)
      rd(ra[i], re[i]);
    wr(`CCW_ADDR_CTRL0, 8'h88);
    ticks(2);
    rd(`CCW_ADDR_HOUR, 16'h0000);
    // Subcounter restarts on a second write
    wr(`CCW_ADDR_CTRL0, 8'h80);
    wr(`CCW_ADDR_SEC, 8'h30);
    ticks(4);
    rd(`CCW_ADDR_SUBC_LO, 16'h0003);
    // Short second from here on: eight ticks
    drift_correction = 16'h0007;
    wr(`CCW_ADDR_SEC, 8'h10);
    ticks(1);
    wr(`CCW_ADDR_CTRL1, 8'h19);
    ticks(1);
    rd(`CCW_ADDR_CTRL1, 16'h0003, 16'h0003);
    ticks(9);
    rd(`CCW_ADDR_SEC, 16'h0010);
    wr(`CCW_ADDR_CTRL1, 8'h18);
    ticks(2);
    rd(`CCW_ADDR_SEC, 16'h0011);
    wr(`CCW_ADDR_CTRL1, 8'h19);
    ticks(8);
    wr(`CCW_ADDR_SEC, 8'h30);
    wr(`CCW_ADDR_CTRL1, 8'h18);
    ticks(3);
    rd(`CCW_ADDR_SEC, 16'h0030);
    // Full carry chain through the calendar cases
    foreach (cs[i]) begin
      wr(`CCW_ADDR_CTRL0, cs[i][0][0] ? 8'h8A : 8'h82);
      month_bcd = cs[i][4][4:0];
      leap_year = cs[i][5][0];
      wr(`CCW_ADDR_SEC, 8'h59);
      wr(`CCW_ADDR_MIN, 8'h59);
      wr(`CCW_ADDR_HOUR, cs[i][1]);
      wr(`CCW_ADDR_DAY, cs[i][2]);
      wr(`CCW_ADDR_WEEK, cs[i][3]);
      ticks(1);
      j = n_cal;
      k = n_carry;
      ticks(10);
      rd(`CCW_ADDR_SEC, 16'h0000);
      rd(`CCW_ADDR_MIN, 16'h0000);
      rd(`CCW_ADDR_HOUR, {8'h00, cs[i][6]});
      rd(`CCW_ADDR_DAY, {8'h00, cs[i][7]});
      rd(`CCW_ADDR_WEEK, {8'h00, cs[i][8]});
      chk(16'(n_carry - k), {8'h00, cs[i][9]});
      chk(16'(n_cal - j), 16'h0001);
      rd(`CCW_ADDR_CTRL1, 16'h0008, 16'h0018);
      wr(`CCW_ADDR_CTRL1, 8'h10);
      rd(`CCW_ADDR_CTRL1, 16'h0000, 16'h0018);
    end
    // Alarm shares the request line
    wr(`CCW_ADDR_CTRL1, 8'hC0);
    j = n_cal;
    alarm_match = 1'b1;
    cyc();
    alarm_match = 1'b0;
    ticks(2);
    rd(`CCW_ADDR_CTRL1, 16'h0010, 16'h0018);
    chk(16'(n_cal - j), 16'h0001);
    wr(`CCW_ADDR_CTRL1, 8'hD8);
    rd(`CCW_ADDR_CTRL1, 16'h0010, 16'h0018);
    wr(`CCW_ADDR_CTRL1, 8'h00);
    wr(`CCW_ADDR_CTRL0, 8'h80);
    drift_correction = 16'h7FFF;
    // Every interval code, select set while disabled
    for (int s = 0; s < 8; s++) begin
      wr(`CCW_ADDR_CTRL2, 8'(s));
      rd(`CCW_ADDR_CTRL2, 16'(s));
      j = n_ivl;
      ticks(64);
      chk(16'(n_ivl - j), 16'h0000);
      wr(`CCW_ADDR_CTRL2, 8'h80 | 8'(s));
      j = n_ivl;
      ticks(1 << (6 + (s > 6 ? 6 : s)));
      chk(16'(n_ivl - j), 16'h0001);
      wr(`CCW_ADDR_CTRL2, 8'h00);
    end
    // Divided pin at both rates, then stopped
    wr(`CCW_ADDR_CTRL2, 8'h60);
    cyc(2);
    j = n_div;
    ticks(64);
    cyc();
    chk(16'(n_div - j), 16'h0020);
    wr(`CCW_ADDR_CTRL2, 8'h40);
    cyc(2);
    j = n_div;
    ticks(128);
    cyc();
    chk(16'(n_div - j), 16'h0002);
    wr(`CCW_ADDR_CTRL2, 8'h00);
    cyc(2);
    chk({15'h0000, divided_clock_pin}, 16'h0000);
    j = n_div;
    ticks(64);
    chk(16'(n_div - j), 16'h0000);
    stop_test();
  end
endmodule  // tb
